// ==== common/ascif_pkg.sv ====
// Purpose: shared constants and types for the serial control interface
// Assumes: 100 MHz system clock, 8-bit control byte, 14-bit result
// Notes: all field positions, codes and counts live here
package ascif_pkg;

    // system clock period
    localparam int CLK_NS = 10;

    // control byte layout
    localparam int CTRL_W = 8;
    localparam int BIT_START = 7;
    localparam int BIT_RANGE = 6;
    localparam int BIT_CLKSEL = 5;
    localparam int BIT_M1 = 4;
    localparam int BIT_M0 = 3;
    localparam int BIT_P2 = 2;
    localparam int BIT_P1 = 1;
    localparam int BIT_P0 = 0;

    // result width
    localparam int RES_W = 14;

    // mode field codes {mode_bit_hi, mode_bit_lo}
    localparam logic [1:0] MODE_SHORT = 2'h0;
    localparam logic [1:0] MODE_CAL = 2'h1;
    localparam logic [1:0] MODE_PDOWN = 2'h2;
    localparam logic [1:0] MODE_LONG = 2'h3;

    // serial clock falls counted from the start bit
    localparam logic [5:0] SHORT_TOTAL = 6'h18;  // 24 clocks
    localparam logic [5:0] LONG_TOTAL = 6'h20;   // 32 clocks
    localparam logic [5:0] SHORT_MSB = 6'h08;    // msb out on 8th fall
    localparam logic [5:0] LONG_MSB = 6'h10;     // msb out on 16th fall
    localparam logic [5:0] CAL_EXT_TOTAL = 6'h28; // calibration length

    // internal conversion clock figures
    localparam int CONV_INT_NS = 4000;
    localparam int CAL_INT_NS = 20000;
    localparam logic [11:0] CONV_INT_CYC = 12'(CONV_INT_NS / CLK_NS);
    localparam logic [11:0] CAL_INT_CYC = 12'(CAL_INT_NS / CLK_NS);

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [2:0] PINS_RST = 3'h7;  // cs_n, reset pin, shutdown

    // control states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_EXT_CONV,
        ST_INT_CONV,
        ST_READ,
        ST_CAL,
        ST_PDOWN,
        ST_SHUTDOWN_IN_N
    } ascif_state_t;

    // fall count at which the msb leaves for a conversion mode
    function automatic logic [5:0] msb_fall(input logic [1:0] mode);
        msb_fall = (mode == MODE_LONG) ? LONG_MSB : SHORT_MSB;
    endfunction

    // true for the two conversion modes
    function automatic logic is_conv(input logic [1:0] mode);
        is_conv = (mode == MODE_SHORT) || (mode == MODE_LONG);
    endfunction

endpackage

// ==== rtl/ascif_sync.sv ====
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels relative to the clock
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module ascif_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q; // first stage, read only by q_o

    // two flops in series
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // ascif_sync
`default_nettype wire

// ==== rtl/ascif_top.sv ====
// Purpose: serial control byte interpreter and result interface
// Assumes: pins arrive asynchronously; converter core gives raw codes
// Notes: serial clock is oversampled by the system clock
`timescale 1ns/100ps
`default_nettype none
module ascif_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    output logic conversion_strobe_o,
    output logic conversion_strobe_oe_n_o,
    // control pins
    input wire logic rst_n_i,
    input wire logic shutdown_in_n_i,
    // converter core raw code
    input wire logic [ascif_pkg::RES_W-1:0] conv_data_i,
    // user outputs
    output logic user_out_0_o,
    output logic user_out_1_o,
    output logic user_out_2_o,
    // status
    output logic range_select_o,
    output logic conv_clock_select_o,
    output logic conv_busy_o,
    output logic cal_busy_o,
    output logic powered_down_o
);
    import ascif_pkg::*;

    logic [1:0] rst_sync_q; // reset release chain
    logic rst_n; // released reset
    logic sclk_s; // synchronised serial clock
    logic din_s; // synchronised serial data
    logic cs_n_s; // synchronised chip select
    logic rst_pin_s; // synchronised reset pin
    logic shutdown_in_n_s; // synchronised shutdown pin
    logic sclk_d_q; // serial clock one cycle back
    logic rise; // serial clock rising edge
    logic fall; // serial clock falling edge
    ascif_state_t state_q; // control state
    logic [CTRL_W-1:0] sr_q; // incoming control bits
    logic [2:0] bit_cnt_q; // bits of byte received
    logic [5:0] fall_cnt_q; // falls since start bit
    logic [5:0] nxt_fall; // fall count after this fall
    logic [11:0] timer_q; // internal clock cycle count
    logic [CTRL_W-1:0] ctrl_q; // last accepted control byte
    logic [CTRL_W-1:0] new_byte; // byte completing this rise
    logic [CTRL_W-1:0] view; // control fields known so far
    logic active; // interface selected and awake
    logic byte_done; // last control bit arrives
    logic int_done; // internal conversion finishes
    logic start_bit; // start bit seen outside a byte
    logic [RES_W-1:0] res_q; // internally converted result
    logic int_pend_q; // internal result awaits a fall
    logic strobe_q; // strobe level
    logic tx_load; // present msb at this fall
    logic tx_dout; // serial bit from shifter
    logic dout_oe_n_q; // dout enable
    logic strobe_oe_n_q; // strobe enable
    logic [2:0] user_q; // user output port register
    logic conv_busy_q; // conversion status
    logic cal_busy_q; // calibration status
    logic pdown_q; // power-down status

    // release the asynchronous reset through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // serial clock and data share one synchroniser delay
    ascif_sync #(.W(2), .RST_VAL(2'h0)) u_sync_ser (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i({sclk_i, din_i}),
        .q_o({sclk_s, din_s})
    );

    // select and control pins, idle high
    ascif_sync #(.W(3), .RST_VAL(PINS_RST)) u_sync_ctl (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i({cs_n_i, rst_n_i, shutdown_in_n_i}),
        .q_o({cs_n_s, rst_pin_s, shutdown_in_n_s})
    );

    // serial clock edge finder
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end
    assign rise = sclk_s & ~sclk_d_q;
    assign fall = ~sclk_s & sclk_d_q;

    // shared event terms
    assign active = rst_pin_s & shutdown_in_n_s & ~cs_n_s;
    assign nxt_fall = fall_cnt_q + 6'h01;
    assign new_byte = {sr_q[CTRL_W-2:0], din_s};
    assign byte_done = active && state_q == ST_SHIFT && rise
        && bit_cnt_q == 3'h7;
    assign int_done = active && state_q == ST_INT_CONV
        && timer_q == CONV_INT_CYC - 12'h001;
    assign start_bit = active && rise && din_s
        && (state_q == ST_IDLE || state_q == ST_PDOWN
        || state_q == ST_EXT_CONV || state_q == ST_INT_CONV
        || state_q == ST_READ);
    // fields already known while the byte still arrives
    assign view = (state_q == ST_SHIFT) ? {sr_q[CTRL_W-2:0], 1'b0}
        : ctrl_q;

    // control state machine
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            sr_q <= CTRL_RST;
            bit_cnt_q <= 3'h0;
            fall_cnt_q <= 6'h00;
            timer_q <= 12'h000;
            ctrl_q <= CTRL_RST;
        end else if (!rst_pin_s) begin // back to power-on
            state_q <= ST_IDLE;
            sr_q <= CTRL_RST;
            bit_cnt_q <= 3'h0;
            fall_cnt_q <= 6'h00;
            timer_q <= 12'h000;
            ctrl_q <= CTRL_RST;
        end else if (!shutdown_in_n_s) begin // stop converting
            state_q <= ST_SHUTDOWN_IN_N;
            bit_cnt_q <= 3'h0;
        end else if (cs_n_s) begin // deselect
            if (state_q != ST_PDOWN) begin
                state_q <= ST_IDLE;
            end
            bit_cnt_q <= 3'h0;
        end else if (start_bit) begin
            state_q <= ST_SHIFT;
            sr_q <= 8'h01;
            bit_cnt_q <= 3'h1;
            fall_cnt_q <= 6'h00;
        end else begin
            case (state_q)
                ST_SHUTDOWN_IN_N: begin // wake waiting for a start bit
                    state_q <= ST_IDLE;
                end
                ST_SHIFT: begin
                    if (rise) begin // one bit per rise
                        sr_q <= new_byte;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                    end
                    if (fall) begin
                        fall_cnt_q <= nxt_fall;
                    end
                    if (byte_done) begin
                        ctrl_q <= new_byte;
                        timer_q <= 12'h000;
                        // mode decode
                        case (new_byte[BIT_M1:BIT_M0])
                            MODE_PDOWN: state_q <= ST_PDOWN;
                            MODE_CAL: state_q <= ST_CAL;
                            default: begin
                                if (new_byte[BIT_CLKSEL]) begin
                                    state_q <= ST_INT_CONV;
                                end else begin
                                    state_q <= ST_EXT_CONV;
                                end
                            end
                        endcase
                    end
                end
                ST_EXT_CONV: begin // serial clock steps it
                    if (fall) begin
                        fall_cnt_q <= nxt_fall;
                        if (nxt_fall == ((ctrl_q[BIT_M1:BIT_M0]
                            == MODE_LONG) ? LONG_TOTAL : SHORT_TOTAL))
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_INT_CONV: begin // own clock paces it
                    timer_q <= timer_q + 12'h001;
                    if (int_done) begin
                        state_q <= ST_READ;
                    end
                end
                ST_CAL: begin // clock chosen by the byte
                    if (ctrl_q[BIT_CLKSEL]) begin
                        timer_q <= timer_q + 12'h001;
                        if (timer_q == CAL_INT_CYC - 12'h001) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (fall) begin
                        fall_cnt_q <= nxt_fall;
                        if (nxt_fall == CAL_EXT_TOTAL) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin // idle, read-out and power-down wait
                end
            endcase
        end
    end

    // conversion strobe level
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= 1'b0;
        end else if (!rst_pin_s) begin // reset pin clears it
            strobe_q <= 1'b0;
        end else if (!active) begin // idle level per clock mode
            strobe_q <= ctrl_q[BIT_CLKSEL];
        end else if (byte_done && new_byte[BIT_CLKSEL]
            && is_conv(new_byte[BIT_M1:BIT_M0])) begin
            strobe_q <= 1'b0; // conversion begins
        end else if (int_done) begin
            strobe_q <= 1'b1; // result complete
        end else if (start_bit && state_q == ST_INT_CONV) begin
            strobe_q <= 1'b1; // aborted, idle high again
        end else if (fall && !view[BIT_CLKSEL]
            && is_conv(view[BIT_M1:BIT_M0])
            && (state_q == ST_SHIFT || state_q == ST_EXT_CONV)) begin
            // one serial clock high before the msb
            if (nxt_fall == msb_fall(view[BIT_M1:BIT_M0]) - 6'h01) begin
                strobe_q <= 1'b1;
            end else if (nxt_fall == msb_fall(view[BIT_M1:BIT_M0]))
            begin
                strobe_q <= 1'b0;
            end else if (nxt_fall >= 6'h05) begin
                // leftover internal idle high drops to low
                strobe_q <= 1'b0;
            end
        end
    end

    // internal result capture and pending read-out
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= '0;
            int_pend_q <= 1'b0;
        end else if (int_done) begin // set beats clear
            res_q <= conv_data_i;
            int_pend_q <= 1'b1;
        end else if (!active || start_bit || fall) begin
            int_pend_q <= 1'b0;
        end
    end

    // msb goes out during or after conversion
    assign tx_load = active && ((state_q == ST_EXT_CONV
        && nxt_fall == msb_fall(ctrl_q[BIT_M1:BIT_M0]))
        || int_pend_q);

    // result shifter, msb first in range coding
    ascif_tx u_tx (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .fall_i(fall),
        .load_i(tx_load),
        .clear_i(cs_n_s || !rst_pin_s),
        .unipolar_i(ctrl_q[BIT_RANGE]),
        .data_i(int_pend_q ? res_q : conv_data_i),
        .dout_o(tx_dout)
    );

    // output enables follow chip select; strobe enable stays on with internal clock
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dout_oe_n_q <= 1'b1;
            strobe_oe_n_q <= 1'b1;
        end else begin
            dout_oe_n_q <= cs_n_s;
            strobe_oe_n_q <= cs_n_s && !ctrl_q[BIT_CLKSEL];
        end
    end

    // user output port register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            user_q <= 3'h0;
        end else if (!rst_pin_s) begin // reset pin clears
            user_q <= 3'h0;
        end else if (byte_done) begin
            user_q <= {new_byte[BIT_P2], new_byte[BIT_P1],
                new_byte[BIT_P0]};
        end // held through shutdown
    end

    // status flags
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_busy_q <= 1'b0;
            cal_busy_q <= 1'b0;
            pdown_q <= 1'b0;
        end else begin
            conv_busy_q <= state_q == ST_EXT_CONV
                || state_q == ST_INT_CONV;
            cal_busy_q <= state_q == ST_CAL;
            pdown_q <= state_q == ST_PDOWN || state_q == ST_SHUTDOWN_IN_N;
        end
    end

    // pins and status straight from flops
    assign dout_o = tx_dout;
    assign dout_oe_n_o = dout_oe_n_q;
    assign conversion_strobe_o = strobe_q;
    assign conversion_strobe_oe_n_o = strobe_oe_n_q;
    assign user_out_2_o = user_q[2];
    assign user_out_1_o = user_q[1];
    assign user_out_0_o = user_q[0];
    assign range_select_o = ctrl_q[BIT_RANGE];
    assign conv_clock_select_o = ctrl_q[BIT_CLKSEL];
    assign conv_busy_o = conv_busy_q;
    assign cal_busy_o = cal_busy_q;
    assign powered_down_o = pdown_q;
endmodule // ascif_top
`default_nettype wire

// ==== rtl/ascif_tx.sv ====
// Purpose: result output shifter for the serial data output
// Assumes: fall_i is a one-cycle serial clock falling edge pulse
// Notes: bipolar results leave as two's complement
`timescale 1ns/100ps
`default_nettype none
module ascif_tx
    import ascif_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic fall_i,
    input wire logic load_i,
    input wire logic clear_i,
    input wire logic unipolar_i,
    input wire logic [ascif_pkg::RES_W-1:0] data_i,
    // serial output bit
    output logic dout_o
);
    logic [RES_W-1:0] sr_q; // bits still to send
    logic [RES_W-1:0] coded; // result in output coding

    // offset binary raw code; flip msb for two's complement
    always_comb begin
        coded = data_i;
        if (!unipolar_i) begin
            coded[RES_W-1] = ~data_i[RES_W-1];
        end
    end

    // load or shift only on serial clock falls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_q <= '0;
            dout_o <= 1'b0;
        end else if (clear_i) begin // pin is tristated only while deselected
            sr_q <= '0;
            dout_o <= 1'b0;
        end else if (fall_i && load_i) begin
            dout_o <= coded[RES_W-1];
            sr_q <= {coded[RES_W-2:0], 1'b0};
        end else if (fall_i) begin // zeros follow the lsb
            dout_o <= sr_q[RES_W-1];
            sr_q <= {sr_q[RES_W-2:0], 1'b0};
        end
    end
endmodule // ascif_tx
`default_nettype wire

// ==== tb/adc_serial_control_interface_bench.sv ====
// Purpose: self-checking bench for the serial interface
// Assumes: host model paces the serial clock at 125 ns
// Notes: random control bytes from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module adc_serial_control_interface_bench;
    import ascif_pkg::*;
    logic clk_i = 1'b0; // system clock
    logic arst_n_i = 1'b0; // bench reset
    logic rst_n_i = 1'b1; // device reset pin
    logic shutdown_in_n_i = 1'b1; // shutdown pin
    logic [RES_W-1:0] conv_data_i = '0; // raw core code
    logic sclk_i, cs_n_i, din_i, dout_o, dout_oe_n_o; // link
    logic strb, strb_oe_n, u0, u1, u2, rng, csel, busy, cal, pdn;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0; // timeout count
    logic [7:0] b; // current control byte
    logic [RES_W-1:0] raw; // code fed to the core input
    logic [2:0] outs; // user outputs as one field
    assign outs = {u2, u1, u0};
    always #(CLK_NS / 2) clk_i = ~clk_i;
    ascif_top u_dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
        .dout_oe_n_o(dout_oe_n_o), .conversion_strobe_o(strb),
        .conversion_strobe_oe_n_o(strb_oe_n), .rst_n_i(rst_n_i),
        .shutdown_in_n_i(shutdown_in_n_i), .conv_data_i(conv_data_i),
        .user_out_0_o(u0), .user_out_1_o(u1), .user_out_2_o(u2),
        .range_select_o(rng), .conv_clock_select_o(csel),
        .conv_busy_o(busy), .cal_busy_o(cal), .powered_down_o(pdn));
    ascif_host_model u_host (
        .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i),
        .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));
    // expected result: binary, or two's complement of offset code
    function automatic logic [RES_W-1:0] exp_code(
            input logic [RES_W-1:0] r, input logic uni);
        return uni ? r : r ^ 14'h2000;
    endfunction
    // report counts, verdict, end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one whole control byte exchange, any mode
    task automatic run(input logic [7:0] cb, input int lead);
        @(negedge clk_i);
        raw = RES_W'($urandom);
        conv_data_i = raw;
        u_host.sel(1'b1);
        case (cb[4:3])
            MODE_CAL: begin
                u_host.clk_bits(cb, lead, lead + 8);
                repeat (8) @(negedge clk_i);
                `CHK(cal, 1'b1)
                if (cb[5]) begin
                    for (int k = 0; k < 2500 && cal; k++) @(negedge clk_i);
                end else begin
                    u_host.clk_bits(8'h00, 0, 31);
                    repeat (8) @(negedge clk_i);
                    `CHK(cal, 1'b1)
                    u_host.clk_bits(8'h00, 0, 1);
                end
                repeat (8) @(negedge clk_i);
                `CHK(cal, 1'b0)
            end
            MODE_PDOWN: begin
                u_host.clk_bits(cb, lead, lead + 8);
                repeat (8) @(negedge clk_i);
                `CHK(pdn, 1'b1)
            end
            default: begin
                if (cb[5]) begin
                    u_host.clk_bits(cb, lead, lead + 8);
                    `CHK(strb, 1'b0)
                    `CHK(busy, 1'b1)
                    for (int k = 0; k < 600 && !strb; k++) @(negedge clk_i);
                    `CHK(strb, 1'b1)
                    u_host.clk_bits(8'h00, 0, 15);
                    `CHK(u_host.cap[13:0], exp_code(raw, cb[6]))
                end else begin
                    u_host.clk_bits(cb, lead, lead + (cb[4] ? 32 : 24));
                    `CHK(u_host.cap[15:0], {exp_code(raw, cb[6]), 2'h0})
                end
            end
        endcase
        `CHK(outs, cb[2:0])
        `CHK({rng, csel}, cb[6:5])
        u_host.sel(1'b0);
        repeat (6) @(negedge clk_i);
        `CHK({dout_oe_n_o, strb_oe_n}, {1'b1, !cb[5]})
    endtask
    // time limit
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            give_verdict();
        end
    end
    // main sequence
    initial begin
        void'($urandom(84192));
        repeat (5) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        `CHK({outs, dout_oe_n_o}, 4'h1)
        for (int i = 0; i < 16; i++) begin
            b = {1'b1, 1'($urandom), 3'(i), 3'($urandom)};
            run(b, $urandom_range(3));
        end
        u_host.clk_bits({5'h10, ~b[2:0]}, 0, 8); // while deselected
        repeat (6) @(negedge clk_i);
        `CHK(outs, b[2:0])
        u_host.sel(1'b1);
        u_host.clk_bits(8'h80, 0, 12); // then deselect mid conversion
        u_host.sel(1'b0);
        run(8'hC5, 0);
        u_host.sel(1'b1);
        u_host.clk_bits(8'h9A, 0, 14); // new start bit mid conversion
        run(8'hC1, 0);
        shutdown_in_n_i = 1'b0;
        repeat (10) @(negedge clk_i);
        `CHK(pdn, 1'b1)
        `CHK(outs, 3'h1)
        shutdown_in_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        run(8'hE7, 1);
        rst_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        `CHK({outs, rng, csel}, 5'h00)
        rst_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        give_verdict();
    end
endmodule // adc_serial_control_interface_bench
`default_nettype wire

// ==== tb/ascif_host_model.sv ====
// Purpose: serial host model driving the link pins
// Assumes: 125 ns serial clock, idle low between frames
// Notes: din shows the inverse of its last bit when idle
`timescale 1ns/100ps
`default_nettype none
module ascif_host_model (
    // link pins toward the device
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    // device answer
    input wire logic dout_i,
    input wire logic dout_oe_n_i
);
    localparam realtime HALF = 62.5; // half serial period
    logic [31:0] cap; // dout bits, newest in bit 0
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
        cap = '0;
    end
    // select or deselect with margin on both sides
    task automatic sel(input logic on);
        #(HALF);
        cs_n_o = !on;
        #(HALF);
    endtask
    // clock n bits: lead zeros, the byte, then zeros
    task automatic clk_bits(input logic [7:0] cb, input int lead,
                            input int n);
        for (int i = 0; i < n; i++) begin
            din_o = (i >= lead && i < lead + 8) ? cb[7 - (i - lead)] : 1'b0;
            #(HALF);
            sclk_o = 1'b1; // din settled half a period before
            cap = {cap[30:0], dout_oe_n_i ? 1'bz : dout_i};
            #(HALF);
            sclk_o = 1'b0;
        end
        din_o = ~din_o; // no stale level between frames
    endtask
endmodule // ascif_host_model
`default_nettype wire

// ==== tb/ascif_top_monitor.sv ====
// Purpose: port checker for the serial interface
// Assumes: pins asynchronous, seen 2-4 clocks late
// Notes: serial clock edge ages come from the raw pin
`timescale 1ns/100ps
`default_nettype none
module ascif_top_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic rst_n_i,
    input wire logic shutdown_in_n_i,
    // outputs watched
    input wire logic dout_o,
    input wire logic dout_oe_n_o,
    input wire logic conversion_strobe_o,
    input wire logic conversion_strobe_oe_n_o,
    input wire logic user_out_0_o,
    input wire logic user_out_1_o,
    input wire logic user_out_2_o,
    input wire logic conv_clock_select_o,
    input wire logic powered_down_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic sclk_q; // last pin level
    logic [3:0] fall_age_q; // clocks since a fall, saturating
    logic [3:0] rise_age_q; // clocks since a rise, saturating
    logic [2:0] outs; // user outputs as one field
    assign outs = {user_out_2_o, user_out_1_o, user_out_0_o};
    // edge ages of the serial clock pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_q <= 1'b0;
            fall_age_q <= 4'hF;
            rise_age_q <= 4'hF;
        end else begin
            sclk_q <= sclk_i;
            if (sclk_q && !sclk_i) fall_age_q <= 4'h0;
            else if (fall_age_q != 4'hF) fall_age_q <= fall_age_q + 4'h1;
            if (!sclk_q && sclk_i) rise_age_q <= 4'h0;
            else if (rise_age_q != 4'hF) rise_age_q <= rise_age_q + 4'h1;
        end
    end
    chk_dout_hiz: assert property (
        cs_n_i [*4] |-> dout_oe_n_o) else $error("dout driven deselected");
    chk_strobe_hiz: assert property (
        (cs_n_i && !conv_clock_select_o) [*4] |-> conversion_strobe_oe_n_o)
        else $error("strobe driven deselected");
    chk_dout_on_fall: assert property (
        $changed(dout_o) && !dout_oe_n_o && !$past(dout_oe_n_o)
        |-> fall_age_q < 4'h7) else $error("dout moved off a fall");
    chk_strobe_one_clk: assert property (
        $rose(conversion_strobe_o) && !conv_clock_select_o
        ##1 !conv_clock_select_o |-> conversion_strobe_o [*7]
        ##[3:7] !conversion_strobe_o) else $error("strobe width wrong");
    chk_outs_on_rise: assert property (
        $changed(outs) && rst_n_i |-> rise_age_q < 4'h7)
        else $error("user outputs moved off a rise");
    chk_outs_reset: assert property (
        !rst_n_i [*5] |-> outs == 3'h0) else $error("user outputs not clear");
    chk_shutdown_in_n_down: assert property (
        !shutdown_in_n_i [*6] |-> powered_down_o)
        else $error("shutdown not entered");
    chk_shutdown_in_n_hold: assert property (
        (!shutdown_in_n_i && rst_n_i) [*4] |=> $stable(outs))
        else $error("user outputs moved in shutdown");
endmodule // ascif_top_monitor
bind ascif_top ascif_top_monitor u_mon (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .rst_n_i(rst_n_i), .shutdown_in_n_i(shutdown_in_n_i), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o), .conversion_strobe_o(conversion_strobe_o),
    .conversion_strobe_oe_n_o(conversion_strobe_oe_n_o),
    .user_out_0_o(user_out_0_o), .user_out_1_o(user_out_1_o),
    .user_out_2_o(user_out_2_o), .conv_clock_select_o(conv_clock_select_o),
    .powered_down_o(powered_down_o));
`default_nettype wire
